// ==== hdl/config_set_manager.sv ====
// configuration set manager: boot load, activate, save, upload and download
`timescale 1ns/1ps
module config_set_manager
  import cfg_set_pkg::*;
#(
  parameter int unsigned user_files = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // decoded register command from the serial command decoder
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_class,
  input wire bulk_cmd_s cmd,
  // upload words from the host
  input wire logic up_valid,
  input wire set_word_s up_word,
  // download stream to the host
  output logic dn_valid,
  input wire logic dn_ready,
  output logic [word_w-1:0] dn_data,
  // work set read port for feature logic
  input wire logic [idx_w-1:0] work_idx,
  output logic [word_w-1:0] work_data,
  // status
  output logic [1:0] bulk_status,
  output logic [2:0] active_file,
  output logic work_valid
);
  typedef enum {s_boot, s_copy, s_idle, s_dload, s_save, s_upload} state_e;
  state_e state, next_state;
  logic [word_w-1:0] work [set_words];
  logic [idx_w-1:0] idx, next_idx;
  logic [2:0] file, next_file;
  logic [1:0] status, next_status;
  logic [2:0] act, next_act;
  logic valid, next_valid;
  logic copy_act, next_copy_act;
  logic [word_w-1:0] rd_data;
  logic [2:0] rec_q;
  logic rec_wr;
  logic st_wr;
  logic [word_w-1:0] st_wdata;
  logic [idx_w-1:0] st_widx;
  logic [word_w-1:0] wdata_q;
  logic work_wr;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [word_w+idx_w-1:0] fifo_out;
  logic [word_w-1:0] dn_q;
  logic dn_v;
  logic [2:0] boot_file;
  logic file_ok, cmd_take, last;
  logic next_dn_v;
  logic [word_w-1:0] next_dn_q, next_work_data;
  logic [4:0] copy_cnt, next_copy_cnt;

  cfg_store #(.files(5)) u_store (
    .mclk(mclk),
    .rd_file(file),
    .rd_idx(idx),
    .rd_data(rd_data),
    .wr_en(st_wr),
    .wr_file(file),
    .wr_idx(st_widx),
    .wr_data(st_wdata),
    .rec_wr(rec_wr),
    .rec_data(file),
    .rec_q(rec_q)
  );

  cfg_fifo #(.width(word_w + idx_w), .depth(fifo_depth)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({idx, rd_data}),
    .out_valid(fifo_out_valid),
    .out_ready(!dn_v || dn_ready),
    .out_data(fifo_out)
  );

  // unknown or absent record means factory
  always_comb begin
    boot_file = file_factory;
    if (rec_q >= file_user_one && rec_q <= 3'(user_files)) begin
      boot_file = rec_q;
    end
  end

  // user files beyond the variant count do not exist
  assign file_ok = (cmd.file == file_factory) || (cmd.file >= file_user_one
                   && cmd.file <= 3'(user_files));
  assign cmd_take = cmd_valid && cmd_class == cls_bulk && state == s_idle;
  assign last = (idx == idx_w'(set_words - 1));
  assign fifo_in_valid = (state == s_dload);
  assign work_wr = (state == s_copy);
  assign rec_wr = (state == s_copy) && last && copy_act;
  assign st_wr = (state == s_save) || (state == s_upload && up_valid);
  assign st_widx = (state == s_upload) ? up_word.idx : idx;
  assign st_wdata = (state == s_upload) ? up_word.data : wdata_q;
  assign wdata_q = work[idx];

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_file = file;
    next_status = status;
    next_act = act;
    next_valid = valid;
    next_copy_act = copy_act;
    case (state)
      s_boot: begin
        next_file = boot_file;
        next_act = boot_file;
        next_idx = '0;
        next_copy_act = 1'b0;
        next_status = st_busy;
        next_state = s_copy;
      end
      s_copy: begin
        next_idx = idx_w'(idx + 1'b1);
        if (last) begin
          next_valid = 1'b1;
          next_status = st_ok;
          if (copy_act) begin
            next_act = file;
          end
          next_state = s_idle;
        end
      end
      s_idle: begin
        if (cmd_take) begin
          next_idx = '0;
          next_file = cmd.file;
          if (!file_ok) begin
            next_status = st_rejected;
          end else begin
            next_status = st_busy;
            case (cmd.op)
              op_activate: begin
                next_copy_act = 1'b1;
                next_state = s_copy;
              end
              op_download: next_state = s_dload;
              op_upload: begin
                if (cmd.file == file_factory) begin
                  next_status = st_rejected;
                end else begin
                  next_state = s_upload;
                end
              end
              op_save: begin
                if (cmd.file == file_factory) begin
                  next_status = st_rejected;
                end else begin
                  next_state = s_save;
                end
              end
              default: next_status = st_rejected;
            endcase
          end
        end
      end
      s_dload: begin
        if (fifo_in_ready) begin
          next_idx = idx_w'(idx + 1'b1);
          if (last) begin
            next_status = st_ok;
            next_state = s_idle;
          end
        end
      end
      s_save: begin
        next_idx = idx_w'(idx + 1'b1);
        if (last) begin
          next_status = st_ok;
          next_state = s_idle;
        end
      end
      s_upload: begin
        // only the words sent are overwritten; finishing when the last index arrives
        if (up_valid && up_word.idx == idx_w'(set_words - 1)) begin
          next_status = st_ok;
          next_state = s_idle;
        end
      end
      default: next_state = s_boot;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= s_boot;
      idx <= '0;
      file <= file_factory;
      status <= st_busy;
      act <= active_rst;
      valid <= 1'b0;
      copy_act <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      file <= next_file;
      status <= next_status;
      act <= next_act;
      valid <= next_valid;
      copy_act <= next_copy_act;
    end
  end

  always_ff @(posedge mclk) begin
    if (work_wr) begin
      work[idx] <= rd_data;
    end
  end

  // download output register stage; refills whenever it is empty or being taken
  always_comb begin
    next_dn_v = dn_v;
    next_dn_q = dn_q;
    if (!dn_v || dn_ready) begin
      next_dn_v = fifo_out_valid;
      next_dn_q = fifo_out[word_w-1:0];
    end
    next_work_data = valid ? work[work_idx] : '0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dn_v <= 1'b0;
      dn_q <= '0;
      work_data <= '0;
    end else begin
      dn_v <= next_dn_v;
      dn_q <= next_dn_q;
      work_data <= next_work_data;
    end
  end

  // cycles spent in the copy state, watched by the copy length checks
  always_comb begin
    next_copy_cnt = (state == s_copy) ? 5'(copy_cnt + 1'b1) : '0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      copy_cnt <= '0;
    end else begin
      copy_cnt <= next_copy_cnt;
    end
  end

  assign dn_valid = dn_v;
  assign dn_data = dn_q;
  assign bulk_status = status;
  assign active_file = act;
  assign work_valid = valid;

  property p_boot_copy;
    @(posedge mclk) disable iff (sys_rst) $rose(valid) |-> $past(state) == s_copy;
  endproperty
  a_boot_copy: assert property (p_boot_copy)
    else $error("work set valid without a copy");
  property p_no_factory_write;
    @(posedge mclk) disable iff (sys_rst) st_wr |-> file != file_factory;
  endproperty
  a_no_factory_write: assert property (p_no_factory_write)
    else $error("factory file written");
  property p_rec_after_copy;
    @(posedge mclk) disable iff (sys_rst) rec_wr |-> state == s_copy && last;
  endproperty
  a_rec_after_copy: assert property (p_rec_after_copy)
    else $error("record updated before copy end");
  property p_boot_choice;
    @(posedge mclk) disable iff (sys_rst) state == s_boot |=> file == $past(boot_file);
  endproperty
  a_boot_choice: assert property (p_boot_choice)
    else $error("wrong boot file");
  sequence seq_copy_last;
    state == s_copy && copy_cnt == 5'(set_words - 1);
  endsequence
  sequence seq_copy_done;
    state == s_idle && valid;
  endsequence
  property p_copy_len;
    @(posedge mclk) disable iff (sys_rst) seq_copy_last |=> seq_copy_done;
  endproperty
  a_copy_len: assert property (p_copy_len)
    else $error("copy length wrong");
  property p_copy_run;
    @(posedge mclk) disable iff (sys_rst)
      state == s_copy && copy_cnt < 5'(set_words - 1) |=> state == s_copy;
  endproperty
  a_copy_run: assert property (p_copy_run)
    else $error("copy ended early");
  property p_variant;
    @(posedge mclk) disable iff (sys_rst)
      cmd_take && cmd.file > 3'(user_files) && cmd.file != file_factory
      |=> status == st_rejected;
  endproperty
  a_variant: assert property (p_variant)
    else $error("missing user file accepted");
  property p_factory_fallback;
    @(posedge mclk) disable iff (sys_rst)
      state == s_boot && (rec_q == file_none || rec_q == file_factory)
      |=> file == file_factory;
  endproperty
  a_factory_fallback: assert property (p_factory_fallback)
    else $error("no factory fallback");
  property p_dl_state;
    @(posedge mclk) disable iff (sys_rst)
      cmd_take && file_ok && cmd.op == op_download |=> state == s_dload;
  endproperty
  a_dl_state: assert property (p_dl_state)
    else $error("download not started");
  property p_factory_upload;
    @(posedge mclk) disable iff (sys_rst)
      cmd_take && cmd.op == op_upload && cmd.file == file_factory
      |=> status == st_rejected && state == s_idle;
  endproperty
  a_factory_upload: assert property (p_factory_upload)
    else $error("factory upload accepted");
endmodule // config_set_manager

// ==== hdl/cfg_set_pkg.sv ====
// package of constants and carriers for the configuration set manager
package cfg_set_pkg;
  localparam int unsigned set_words = 16;
  localparam int unsigned word_w = 32;
  localparam int unsigned idx_w = 4;
  localparam int unsigned fifo_depth = 8;
  localparam logic [2:0] file_factory = 3'h0;
  localparam logic [2:0] file_user_one = 3'h1;
  localparam logic [2:0] file_user_two = 3'h2;
  localparam logic [2:0] file_user_three = 3'h3;
  localparam logic [2:0] file_user_four = 3'h4;
  localparam logic [2:0] file_none = 3'h7;
  localparam logic [2:0] active_rst = 3'h7;
  localparam logic [1:0] cls_inquiry = 2'h0;
  localparam logic [1:0] cls_feature = 2'h1;
  localparam logic [1:0] cls_bulk = 2'h2;
  localparam logic [1:0] cls_none = 2'h3;
  localparam logic [1:0] op_activate = 2'h0;
  localparam logic [1:0] op_download = 2'h1;
  localparam logic [1:0] op_upload = 2'h2;
  localparam logic [1:0] op_save = 2'h3;
  localparam logic [1:0] st_ok = 2'h0;
  localparam logic [1:0] st_busy = 2'h1;
  localparam logic [1:0] st_rejected = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic [2:0] file;
  } bulk_cmd_s;

  typedef struct packed {
    logic [idx_w-1:0] idx;
    logic [word_w-1:0] data;
  } set_word_s;
endpackage

// ==== hdl/cfg_fifo.sv ====
// buffer of set words between the set store and the serial side
`timescale 1ns/1ps
module cfg_fifo #(
  parameter int unsigned width = 36,
  parameter int unsigned depth = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0] count, next_count;
  logic [aw-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic push, pop;

  assign in_ready = (count != depth[aw:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? aw'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? aw'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      count <= next_count;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // cfg_fifo

// ==== hdl/cfg_store.sv ====
// non-volatile set files and the lasting activated-file record
`timescale 1ns/1ps
module cfg_store
  import cfg_set_pkg::*;
#(
  parameter int unsigned files = 5
) (
  // clock
  input wire logic mclk,
  // word access
  input wire logic [2:0] rd_file,
  input wire logic [idx_w-1:0] rd_idx,
  output logic [word_w-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_file,
  input wire logic [idx_w-1:0] wr_idx,
  input wire logic [word_w-1:0] wr_data,
  // activated-file record
  input wire logic rec_wr,
  input wire logic [2:0] rec_data,
  output logic [2:0] rec_q
);
  // contents model flash: no reset, kept across sys_rst
  logic [word_w-1:0] mem [files*set_words];
  logic [2:0] rec;

  assign rd_data = mem[rd_file*set_words + rd_idx];
  assign rec_q = rec;

  always_ff @(posedge mclk) begin
    if (wr_en && wr_file != file_factory) begin
      mem[wr_file*set_words + wr_idx] <= wr_data;
    end
    if (rec_wr) begin
      rec <= rec_data;
    end
  end
endmodule // cfg_store

// ==== verification/cfg_host_model.sv ====
// host model: bulk commands, upload words and a stalling download sink
`timescale 1ns/1ps
module cfg_host_model
  import cfg_set_pkg::*;
(
  // clock
  input wire logic mclk,
  // command and upload
  output logic cmd_valid,
  output logic [1:0] cmd_class,
  output bulk_cmd_s cmd,
  output logic up_valid,
  output set_word_s up_word,
  // download and status
  input wire logic dn_valid,
  output logic dn_ready,
  input wire logic [word_w-1:0] dn_data,
  input wire logic [1:0] bulk_status
);
  logic [word_w-1:0] got [16];
  int n_got = 0;
  int timed_out = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_class = cls_none;
    cmd = '0;
    up_valid = 1'b0;
    up_word = '0;
    dn_ready = 1'b0;
  end
  always @(posedge mclk) begin
    if (dn_valid && dn_ready && n_got < 16) begin
      got[n_got] <= dn_data;
      n_got <= n_got + 1;
    end
  end
  // one command pulse; cmd does not keep the last value, cmd_class does
  task automatic send(input logic [1:0] cls, input logic [1:0] op, input logic [2:0] file);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_class = cls;
    cmd = '{op: op, file: file};
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && bulk_status === st_busy; i++) begin
      @(posedge mclk);
      #1;
    end
    if (bulk_status === st_busy) timed_out++;
  endtask
  task automatic upload(input logic [2:0] file, input logic [7:0] seed);
    send(cls_bulk, op_upload, file);
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      #1;
      up_valid = 1'b1;
      up_word = '{idx: 4'(i), data: {seed, ~seed, 12'h000, 4'(i)}};
      @(posedge mclk);
      #1;
      up_valid = 1'b0;
      up_word = ~up_word;
    end
    wait_idle();
  endtask
  // host holds off for a while so the buffer fills, then stalls every fourth cycle
  task automatic download(input logic [2:0] file, input int hold);
    n_got = 0;
    send(cls_bulk, op_download, file);
    repeat (hold) @(posedge mclk);
    for (int i = 0; i < 400 && n_got < 16; i++) begin
      #1;
      dn_ready = i[1] | i[0];
      @(posedge mclk);
    end
    #1;
    dn_ready = 1'b0;
    if (n_got < 16) timed_out++;
    wait_idle();
  endtask
endmodule // cfg_host_model

// ==== verification/tb.sv ====
// testbench of the configuration set manager
`timescale 1ns/1ps
module tb;
  import cfg_set_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid;
  logic [1:0] cmd_class;
  bulk_cmd_s cmd;
  logic up_valid;
  set_word_s up_word;
  logic dn_valid;
  logic dn_ready;
  logic [word_w-1:0] dn_data;
  logic [idx_w-1:0] work_idx = '0;
  logic [word_w-1:0] work_data;
  logic [1:0] bulk_status;
  logic [2:0] active_file;
  logic work_valid;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 mclk = ~mclk;
  config_set_manager #(.user_files(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_class(cmd_class), .cmd(cmd), .up_valid(up_valid),
    .up_word(up_word), .dn_valid(dn_valid), .dn_ready(dn_ready), .dn_data(dn_data),
    .work_idx(work_idx), .work_data(work_data), .bulk_status(bulk_status),
    .active_file(active_file), .work_valid(work_valid));
  cfg_host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_class(cmd_class), .cmd(cmd),
    .up_valid(up_valid), .up_word(up_word), .dn_valid(dn_valid), .dn_ready(dn_ready),
    .dn_data(dn_data), .bulk_status(bulk_status));
  function automatic logic [31:0] pat(input logic [7:0] s, input int i);
    return {s, ~s, 12'h000, 4'(i)};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    error_cnt += host.timed_out;
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic wait_loaded();
    for (int i = 0; i < 60 && work_valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("work_valid", 32'h1, {31'h0, work_valid});
  endtask
  task automatic check_work(input logic [7:0] s);
    for (int i = 0; i < 16; i++) begin
      work_idx = 4'(i);
      @(posedge mclk);
      #1;
      chk("work_data", pat(s, i), work_data);
    end
  endtask
  task automatic check_dn(input logic [7:0] s);
    chk("download count", 32'd16, 32'(host.n_got));
    for (int i = 0; i < 16; i++) chk("dn_data", pat(s, i), host.got[i]);
  endtask
  task automatic t_activate(input logic [2:0] f, input logic [7:0] s);
    host.send(cls_bulk, op_activate, f);
    host.wait_idle();
    chk("status", 32'(st_ok), 32'(bulk_status));
    chk("active_file", 32'(f), 32'(active_file));
    if (f != file_factory) check_work(s);
    $display("test activate file %0d done", f);
  endtask
  task automatic t_reset_reload(input logic [2:0] f, input logic [7:0] s);
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("work_valid in reset", 32'h0, {31'h0, work_valid});
    sys_rst = 1'b0;
    @(posedge mclk);
    #1;
    wait_loaded();
    chk("active_file", 32'(f), 32'(active_file));
    check_work(s);
    $display("test reset reload done");
  endtask
  task automatic t_protect();
    host.upload(file_factory, 8'h5a);
    chk("factory upload", 32'(st_rejected), 32'(bulk_status));
    host.send(cls_bulk, op_save, file_factory);
    host.wait_idle();
    chk("factory save", 32'(st_rejected), 32'(bulk_status));
    host.upload(3'h5, 8'h66);
    chk("absent file", 32'(st_rejected), 32'(bulk_status));
    host.download(file_factory, 0);
    chk("factory count", 32'd16, 32'(host.n_got));
    for (int i = 0; i < 16; i++) begin
      chk("factory kept", 32'h0, {31'h0, host.got[i] === pat(8'h5a, i)});
    end
    $display("test protect done");
  endtask
  task automatic t_ignored();
    host.send(cls_feature, op_activate, file_user_one);
    host.wait_idle();
    chk("other class status", 32'(st_ok), 32'(bulk_status));
    chk("other class active", 32'(file_factory), 32'(active_file));
    $display("test other class done");
  endtask
  task automatic t_save(input logic [2:0] f, input logic [7:0] s);
    host.send(cls_bulk, op_save, f);
    host.wait_idle();
    chk("save status", 32'(st_ok), 32'(bulk_status));
    host.download(f, 4);
    check_dn(s);
    $display("test save done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    wait_loaded();
    chk("fresh active", 32'(file_factory), 32'(active_file));
    $display("test boot done");
    host.upload(file_user_one, 8'h11);
    chk("upload status", 32'(st_ok), 32'(bulk_status));
    host.upload(file_user_two, 8'h22);
    host.download(file_user_one, 20);
    check_dn(8'h11);
    host.download(file_user_two, 0);
    check_dn(8'h22);
    $display("test upload download done");
    t_activate(file_user_two, 8'h22);
    t_reset_reload(file_user_two, 8'h22);
    host.upload(file_user_two, 8'h33);
    host.download(file_user_two, 12);
    check_dn(8'h33);
    t_protect();
    host.upload(file_user_four, 8'h44);
    t_activate(file_user_four, 8'h44);
    t_reset_reload(file_user_four, 8'h44);
    t_save(file_user_three, 8'h44);
    t_activate(file_factory, 8'h00);
    t_ignored();
    conclude();
  end
endmodule // tb
